// ==== scs_defines.vh ====
// register addresses, field positions, reset values and counts of the spi configuration block
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// special function register addresses
`define SCS_ADDR_CONTROL     8'hF8
`define SCS_ADDR_CONFIG      8'hA1
`define SCS_ADDR_CLOCK_RATE  8'hA2
`define SCS_ADDR_DATA        8'hA3

// configuration register fields
`define SCS_CFG_BUSY         7
`define SCS_CFG_MASTER       6
`define SCS_CFG_PHASE        5
`define SCS_CFG_POLARITY     4
`define SCS_CFG_SLV_SEL      3
`define SCS_CFG_PIN_LEVEL    2
`define SCS_CFG_SR_EMPTY     1
`define SCS_CFG_RX_EMPTY     0

// control register fields
`define SCS_CTL_DONE         7
`define SCS_CTL_WCOL         6
`define SCS_CTL_MODF         5
`define SCS_CTL_OVERRUN      4
`define SCS_CTL_NSS_MODE_HI  3
`define SCS_CTL_NSS_MODE_LO  2
`define SCS_CTL_TX_ROOM      1
`define SCS_CTL_ENABLE       0

// reset values
`define SCS_CONFIG_RESET     8'h07
`define SCS_CONTROL_RESET    8'h06
`define SCS_CLOCK_RATE_RESET 8'h00

// nss modes
`define SCS_NSS_3WIRE        2'h0
`define SCS_NSS_MULTI        2'h1

// serial timing and buffering
`define SCS_LAST_EDGE        4'hF
`define SCS_FIFO_WIDTH       8
`define SCS_FIFO_DEPTH       16
`define SCS_FIFO_AW          4

`endif

// ==== scs_fifo.v ====
// transmit fifo between the data register and the shift register
`timescale 1ns/1ps
module scs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             arst_n,
	input  wire             ce,
	input  wire             flush,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// full and empty come straight from the occupancy count
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	// storage array has no reset; only pointers and count need a defined value
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and count; flush empties the queue when the port is disabled
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (flush) begin
				wr_ptr <= {AW{1'b0}};
				rd_ptr <= {AW{1'b0}};
				count  <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
				end
				if (pop) begin
					rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
				end
				if (push & ~pop) begin
					count <= count + {{AW{1'b0}}, 1'b1};
				end else if (pop & ~push) begin
					count <= count - {{AW{1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // scs_fifo

// ==== scs_spi_config_status.v ====
// byte-wide spi port with its configuration and status register
// Summary of operation
// - the port is run through four registers only: control, data, configuration and clock rate.
// - configuration bit 2 returns the slave-select pin level after the two-flop synchroniser, with no deglitch filter.
// - shift-register-empty in bit 1 is read only and only means something in slave mode.
// - in slave mode shift-register-empty sets once a byte has fully shifted and none is pending.
// - in slave mode receive-buffer-empty in bit 0 sets once software reads an unrenewed buffer.
// - receive-buffer-empty stays clear while an unread received byte sits in the buffer.
// - the polarity select picks an idle-low or idle-high serial clock in master mode; a slave takes either idle level whatever the select.
// - the phase select picks first or second clock edge for latching; both ends must match.
// - after eight bits the transfer-complete flag sets and the byte goes to the receive buffer, or overrun sets if that still holds an unread byte.
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_spi_config_status (
	input  wire       clk,
	input  wire       arst_n,
	input  wire       ce,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata,
	input  wire       sck_in,
	output wire       sck_out,
	output wire       sck_oe,
	input  wire       mosi_in,
	output wire       mosi_out,
	output wire       mosi_oe,
	input  wire       miso_in,
	output wire       miso_out,
	output wire       miso_oe,
	input  wire       slave_select_pin_in,
	output wire       slave_select_pin_out,
	output wire       slave_select_pin_oe
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	// control register state
	reg        transfer_complete_flag;
	reg        write_collision;
	reg        mode_fault_flag;
	reg        receive_overrun;
	reg [1:0]  nss_mode;
	reg        port_enable;
	// configuration register state, clock rate and receive buffer
	reg        master_enable;
	reg        clock_phase_select;
	reg        clock_polarity_select;
	reg        receive_buffer_empty;
	reg [7:0]  spi_clock_rate;
	reg [7:0]  rx_buffer;
	// shift engine
	reg        master_state;
	reg [7:0]  half_cnt;
	reg        sck_phase;
	reg [3:0]  edge_cnt;
	reg [7:0]  tx_shift;
	reg [7:0]  rx_shift;
	reg        tx_loaded;
	reg        sck_delay;
	// pin synchronisers
	reg [3:0]  pin_meta;
	reg [3:0]  pin_sync;
	wire [3:0] pin_raw;
	wire       sck_s;
	wire       mosi_s;
	wire       miso_s;
	wire       nss_s;

	// register port decode
	wire       wr_control;
	wire       wr_config;
	wire       wr_rate;
	wire       wr_data;
	wire       rd_data;
	// engine terms
	wire       slave_active;
	wire       slave_selected;
	wire       mode_fault;
	wire       master_edge;
	wire       link_edge;
	wire       leading;
	wire       sample_edge;
	wire       shift_edge;
	wire       byte_end;
	wire       sample_bit;
	wire [7:0] rx_next;
	wire       transfer_busy;
	wire       shift_register_empty;
	wire       master_start;
	wire       slave_load;
	wire       buffer_full;
	// fifo
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire       fifo_out_ready;
	wire [7:0] fifo_out_data;
	wire [7:0] config_view;
	wire [7:0] control_view;

	assign pin_raw = {slave_select_pin_in, miso_in, mosi_in, sck_in};

	// every pin passes two flops; only the second flop feeds any logic
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_meta[gi] <= 1'b1;
					pin_sync[gi] <= 1'b1;
				end else if (ce) begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	assign sck_s  = pin_sync[0];
	assign mosi_s = pin_sync[1];
	assign miso_s = pin_sync[2];
	assign nss_s  = pin_sync[3];

	// register strobes, one per mapped address
	assign wr_control = ce & sfr_wr & (sfr_addr == `SCS_ADDR_CONTROL);
	assign wr_config  = ce & sfr_wr & (sfr_addr == `SCS_ADDR_CONFIG);
	assign wr_rate    = ce & sfr_wr & (sfr_addr == `SCS_ADDR_CLOCK_RATE);
	assign wr_data    = ce & sfr_wr & (sfr_addr == `SCS_ADDR_DATA);
	assign rd_data    = ce & sfr_rd & (sfr_addr == `SCS_ADDR_DATA);

	// slave runs when enabled, not master, and selected (3-wire needs no select)
	assign slave_selected = port_enable & ~master_enable & ~nss_s;
	assign slave_active   = port_enable & ~master_enable &
	                        ((nss_mode == `SCS_NSS_3WIRE) | ~nss_s);
	assign mode_fault     = port_enable & master_enable &
	                        (nss_mode == `SCS_NSS_MULTI) & ~nss_s;

	// master makes its own edges; slave finds edges on the synchronised clock
	assign master_edge = (master_state == ST_RUN) & (half_cnt == spi_clock_rate);
	assign link_edge   = master_enable ? master_edge :
	                     (slave_active & (sck_s ^ sck_delay));
	// even edge count is the leading edge of a bit period, whatever the polarity
	assign leading     = ~edge_cnt[0];
	assign sample_edge = link_edge & (clock_phase_select ? ~leading : leading);
	assign shift_edge  = link_edge & (clock_phase_select ? (leading & (edge_cnt != 4'h0)) :
	                     ~leading);
	assign byte_end    = link_edge & (edge_cnt == `SCS_LAST_EDGE);
	assign sample_bit  = master_enable ? miso_s : mosi_s; // miso lags two clocks: rate below 2 misreads
	assign rx_next     = sample_edge ? {rx_shift[6:0], sample_bit} : rx_shift;
	assign buffer_full = ~receive_buffer_empty & ~rd_data;

	assign transfer_busy = (master_state == ST_RUN) |
	                       (slave_active & (edge_cnt != 4'h0));
	assign shift_register_empty = ~tx_loaded;

	// fifo drain stalls while the shift register still holds a byte
	assign master_start   = port_enable & master_enable & ~mode_fault &
	                        (master_state == ST_IDLE) & fifo_out_valid;
	assign slave_load     = port_enable & ~master_enable & fifo_out_valid &
	                        ((~tx_loaded & (edge_cnt == 4'h0) & ~link_edge) | byte_end);
	assign fifo_out_ready = master_start | slave_load;

	scs_fifo #(
		.WIDTH (`SCS_FIFO_WIDTH),
		.DEPTH (`SCS_FIFO_DEPTH),
		.AW    (`SCS_FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.flush     (~port_enable),
		.in_valid  (wr_data),
		.in_ready  (fifo_in_ready),
		.in_data   (sfr_wdata),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// software-facing register state; hardware sets win over software clears
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			transfer_complete_flag <= 1'b0;
			write_collision        <= 1'b0;
			mode_fault_flag        <= 1'b0;
			receive_overrun        <= 1'b0;
			nss_mode               <= `SCS_NSS_MULTI;
			port_enable            <= 1'b0;
			master_enable          <= 1'b0;
			clock_phase_select     <= 1'b0;
			clock_polarity_select  <= 1'b0;
			spi_clock_rate         <= `SCS_CLOCK_RATE_RESET;
			receive_buffer_empty   <= 1'b1;
			rx_buffer              <= 8'h00;
		end else if (ce) begin
			transfer_complete_flag <= byte_end |
			    (wr_control ? sfr_wdata[`SCS_CTL_DONE] : transfer_complete_flag);
			write_collision <= (wr_data & ~fifo_in_ready) |
			    (wr_control ? sfr_wdata[`SCS_CTL_WCOL] : write_collision);
			mode_fault_flag <= mode_fault |
			    (wr_control ? sfr_wdata[`SCS_CTL_MODF] : mode_fault_flag);
			receive_overrun <= (byte_end & buffer_full) |
			    (wr_control ? sfr_wdata[`SCS_CTL_OVERRUN] : receive_overrun);
			if (wr_control) begin
				nss_mode <= sfr_wdata[`SCS_CTL_NSS_MODE_HI:`SCS_CTL_NSS_MODE_LO];
			end
			// a mode fault drops both enables ahead of any software write
			if (mode_fault) begin
				port_enable   <= 1'b0;
				master_enable <= 1'b0;
			end else begin
				if (wr_control) begin
					port_enable <= sfr_wdata[`SCS_CTL_ENABLE];
				end
				if (wr_config) begin
					master_enable <= sfr_wdata[`SCS_CFG_MASTER];
				end
			end
			// phase and polarity take effect at once; a live byte may be corrupted
			if (wr_config) begin
				clock_phase_select    <= sfr_wdata[`SCS_CFG_PHASE];
				clock_polarity_select <= sfr_wdata[`SCS_CFG_POLARITY];
			end
			if (wr_rate) begin
				spi_clock_rate <= sfr_wdata;
			end
			// a new byte outranks a simultaneous read; an unread byte is never overwritten
			if (byte_end & ~buffer_full) begin
				rx_buffer            <= rx_next;
				receive_buffer_empty <= 1'b0;
			end else if (rd_data) begin
				receive_buffer_empty <= 1'b1;
			end
		end
	end

	// shift engine: master clock generation, edge counting and both shift registers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			master_state <= ST_IDLE;
			half_cnt     <= 8'h00;
			sck_phase    <= 1'b0;
			edge_cnt     <= 4'h0;
			tx_shift     <= 8'h00;
			rx_shift     <= 8'h00;
			tx_loaded    <= 1'b0;
			sck_delay    <= 1'b1; // matches the synchroniser reset, so no false edge
		end else if (ce) begin
			sck_delay <= sck_s;
			if (!port_enable) begin
				master_state <= ST_IDLE;
				half_cnt     <= 8'h00;
				sck_phase    <= 1'b0;
				edge_cnt     <= 4'h0;
				tx_loaded    <= 1'b0;
			end else begin
				case (master_state)
					ST_IDLE: begin
						half_cnt  <= 8'h00;
						sck_phase <= 1'b0;
						if (master_start) begin
							master_state <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (master_edge) begin
							half_cnt  <= 8'h00;
							sck_phase <= ~sck_phase;
							if (byte_end) begin
								master_state <= ST_IDLE;
							end
						end else begin
							half_cnt <= half_cnt + 8'h01;
						end
					end
					default: begin
						master_state <= ST_IDLE;
					end
				endcase
				// a deselected slave restarts its bit count on the next select
				if (!(slave_active | master_enable)) begin
					edge_cnt <= 4'h0;
				end else if (link_edge) begin
					edge_cnt <= edge_cnt + 4'h1;
				end
				if (sample_edge) begin
					rx_shift <= {rx_shift[6:0], sample_bit};
				end
				if (master_start | slave_load) begin
					tx_shift  <= fifo_out_data;
					tx_loaded <= 1'b1;
				end else if (byte_end) begin
					tx_loaded <= 1'b0;
				end else if (shift_edge) begin
					tx_shift <= {tx_shift[6:0], 1'b0};
				end
			end
		end
	end

	// status views; pin level is the synchronised level, never filtered
	assign config_view = {transfer_busy, master_enable, clock_phase_select,
	                      clock_polarity_select, slave_selected, nss_s,
	                      shift_register_empty, receive_buffer_empty};
	assign control_view = {transfer_complete_flag, write_collision, mode_fault_flag,
	                       receive_overrun, nss_mode, fifo_in_ready, port_enable};

	// read data is captured on the read strobe; unmapped addresses read zero
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sfr_rdata <= 8'h00;
		end else if (ce & sfr_rd) begin
			case (sfr_addr)
				`SCS_ADDR_CONFIG:     sfr_rdata <= config_view;
				`SCS_ADDR_CONTROL:    sfr_rdata <= control_view;
				`SCS_ADDR_CLOCK_RATE: sfr_rdata <= spi_clock_rate;
				`SCS_ADDR_DATA:       sfr_rdata <= rx_buffer;
				default:              sfr_rdata <= 8'h00;
			endcase
		end
	end

	// pin drivers: master owns clock and mosi, active slave owns miso
	assign sck_out              = clock_polarity_select ^ sck_phase;
	assign sck_oe               = port_enable & master_enable;
	assign mosi_out             = tx_shift[7];
	assign mosi_oe              = port_enable & master_enable;
	assign miso_out             = tx_shift[7];
	assign miso_oe              = slave_active;
	assign slave_select_pin_out = nss_mode[0];
	assign slave_select_pin_oe  = port_enable & master_enable & nss_mode[1];
endmodule // scs_spi_config_status

// ==== scs_chk.sv ====
// concurrent checks on the ports of the spi configuration block
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_chk (
	input wire       clk,
	input wire       arst_n,
	input wire       ce,
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire       sck_out,
	input wire       sck_oe,
	input wire       mosi_oe,
	input wire       miso_oe,
	input wire       slave_select_pin_in,
	input wire       slave_select_pin_out
);
	reg  [2:0] cfg_w;
	reg        nss_lo;
	reg  [1:0] up;
	wire       cfg_rd = ce && sfr_rd && sfr_addr == `SCS_ADDR_CONFIG;
	wire       mapped = sfr_addr == `SCS_ADDR_CONTROL || sfr_addr == `SCS_ADDR_CONFIG
		|| sfr_addr == `SCS_ADDR_CLOCK_RATE || sfr_addr == `SCS_ADDR_DATA;
	// mirrors of written bits; up keeps pin checks off the synchroniser's reset value
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_w <= 3'h0;
			nss_lo <= 1'b1;
			up <= 2'h0;
		end else if (ce) begin
			if (up != 2'h3)
				up <= up + 2'h1;
			if (sfr_wr && sfr_addr == `SCS_ADDR_CONFIG)
				cfg_w <= sfr_wdata[6:4];
			if (sfr_wr && sfr_addr == `SCS_ADDR_CONTROL)
				nss_lo <= sfr_wdata[2];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_unmapped_zero: assert property (ce && sfr_rd && !mapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read returned nonzero");
	a_rdata_holds: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_pin_level: assert property (cfg_rd && up == 2'h3 && $stable(slave_select_pin_in)
		&& $past(slave_select_pin_in, 2) == slave_select_pin_in
		&& $past(slave_select_pin_in, 3) == slave_select_pin_in
		|=> sfr_rdata[2] == $past(slave_select_pin_in))
		else $error("pin level bit wrong");
	a_cfg_back: assert property (cfg_rd && !sfr_wr |=> sfr_rdata[6:4] == $past(cfg_w))
		else $error("config select bits lost");
	a_sck_rests: assert property (cfg_rd && !sfr_wr |=> sfr_rdata[7] || sck_out == cfg_w[0])
		else $error("clock off its idle level while not busy");
	a_ends_apart: assert property (miso_oe |-> !sck_oe && !mosi_oe)
		else $error("slave and master drive at once");
	a_sck_idle_pol: assert property ($rose(sck_oe) |-> sck_out == cfg_w[0])
		else $error("clock starts off its idle level");
	a_ss_out: assert property (slave_select_pin_out == nss_lo)
		else $error("select output not following control");
endmodule // scs_chk
bind scs_spi_config_status scs_chk i_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
	.miso_oe(miso_oe), .slave_select_pin_in(slave_select_pin_in),
	.slave_select_pin_out(slave_select_pin_out));

// ==== scs_far_master.sv ====
// external spi master: idle-low clock, data latched on the first edge
`timescale 1ns/1ps
module scs_far_master (
	input  wire miso,
	output reg  sck,
	output reg  mosi,
	output reg  ss_n
);
	// clock stands still between frames
	initial begin
		sck = 1'b0;
		mosi = 1'b1;
		ss_n = 1'b1;
	end
	// msb first, 160 ns bit period; select falls well ahead of the first edge
	task xfer(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			ss_n = 1'b0;
			for (i = 7; i >= 0; i = i - 1) begin
				mosi = tx[i];
				#80;
				sck = 1'b1;
				rx[i] = miso;
				#80;
				sck = 1'b0;
			end
			mosi = ~tx[0]; // released line shows the inverse
			#80;
			ss_n = 1'b1;
		end
	endtask
endmodule // scs_far_master

// ==== tb.sv ====
// self-checking bench for the spi configuration and status block
`timescale 1ns/1ps
`include "scs_defines.vh"
module tb;
	reg        clk;
	reg        arst_n;
	reg        ce;
	reg  [7:0] sfr_addr;
	reg        sfr_wr;
	reg        sfr_rd;
	reg  [7:0] sfr_wdata;
	reg  [7:0] d;
	reg  [7:0] got;
	wire [7:0] sfr_rdata;
	wire       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
	wire       far_sck, far_mosi, far_ss_n;
	integer    err_count;
	integer    checks_done;
	integer    i;
	// pin levels from whoever drives; in master mode miso is looped back from mosi
	wire       sck_w    = sck_oe ? sck_out : far_sck;
	wire       mosi_w   = mosi_oe ? mosi_out : far_mosi;
	wire       ss_w     = ss_oe ? ss_out : far_ss_n;
	wire       far_miso = miso_oe ? miso_out : ~miso_out;
	scs_spi_config_status i_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
		.mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(mosi_out),
		.miso_out(miso_out), .miso_oe(miso_oe), .slave_select_pin_in(ss_w),
		.slave_select_pin_out(ss_out), .slave_select_pin_oe(ss_oe));
	scs_far_master i_far (.miso(far_miso), .sck(far_sck), .mosi(far_mosi), .ss_n(far_ss_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task end_sim;
		begin
			$display("checks %0d errors %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input string what, input [7:0] exp, input [7:0] seen);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// one-cycle strobes, launched just after an edge
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clk);
			#1;
			sfr_addr = a;
			sfr_wdata = v;
			sfr_wr = 1'b1;
			@(posedge clk);
			#1;
			sfr_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge clk);
			#1;
			sfr_addr = a;
			sfr_rd = 1'b1;
			@(posedge clk);
			#1;
			sfr_rd = 1'b0;
			v = sfr_rdata;
		end
	endtask
	task t_reset_access;
		begin
			rd(`SCS_ADDR_CONFIG, d);
			chk("config reset", 8'h07, d);
			rd(`SCS_ADDR_CONTROL, d);
			chk("control reset", 8'h06, d);
			rd(8'h55, d);
			chk("unmapped", 8'h00, d);
			wr(8'h55, 8'hFF);
			rd(`SCS_ADDR_CLOCK_RATE, d);
			chk("clock rate", 8'h00, d);
			// a frozen clock enable must swallow the write
			ce = 1'b0;
			wr(`SCS_ADDR_CLOCK_RATE, 8'h5A);
			ce = 1'b1;
			rd(`SCS_ADDR_CLOCK_RATE, d);
			chk("frozen write", 8'h00, d);
			wr(`SCS_ADDR_CONFIG, 8'hFF);
			rd(`SCS_ADDR_CONFIG, d);
			chk("config ro bits", 8'h77, d);
			wr(`SCS_ADDR_CONFIG, 8'h00);
		end
	endtask
	// pin level is the synchronised level, even with the port off
	task t_pin;
		begin
			i_far.ss_n = 1'b0;
			repeat (4) @(posedge clk);
			rd(`SCS_ADDR_CONFIG, d);
			chk("pin low", 8'h03, d);
			i_far.ss_n = 1'b1;
			repeat (4) @(posedge clk);
			rd(`SCS_ADDR_CONFIG, d);
			chk("pin high", 8'h07, d);
		end
	endtask
	task t_slave;
		begin
			wr(`SCS_ADDR_CONTROL, 8'h05);
			wr(`SCS_ADDR_DATA, 8'h3C);
			rd(`SCS_ADDR_CONFIG, d);
			chk("loaded", 8'h05, d);
			fork
				i_far.xfer(8'hA5, got);
				begin
					#640;
					rd(`SCS_ADDR_CONFIG, d);
					chk("mid byte", 8'h89, d);
				end
			join
			chk("slave out", 8'h3C, got);
			repeat (4) @(posedge clk);
			rd(`SCS_ADDR_CONFIG, d);
			chk("byte held", 8'h06, d);
			rd(`SCS_ADDR_CONTROL, d);
			chk("done flag", 8'h87, d);
			rd(`SCS_ADDR_DATA, d);
			chk("slave rx", 8'hA5, d);
			rd(`SCS_ADDR_CONFIG, d);
			chk("rx read", 8'h07, d);
			wr(`SCS_ADDR_CONTROL, 8'h00);
		end
	endtask
	// loopback master byte; rate 2 keeps the two-flop miso lag inside a half period
	task t_master(input [7:0] cfg, input [7:0] v);
		begin
			wr(`SCS_ADDR_CLOCK_RATE, 8'h02);
			rd(`SCS_ADDR_CLOCK_RATE, d);
			chk("rate back", 8'h02, d);
			wr(`SCS_ADDR_CONFIG, cfg);
			wr(`SCS_ADDR_CONTROL, 8'h01);
			wr(`SCS_ADDR_DATA, v);
			rd(`SCS_ADDR_CONFIG, d);
			chk("busy", 8'h80, d & 8'h80);
			i = 0;
			while (d[7] !== 1'b0) begin
				i = i + 1;
				if (i > 40) begin
					err_count = err_count + 1;
					$display("[ERR] busy wait expected 0 seen 1");
					end_sim;
				end
				rd(`SCS_ADDR_CONFIG, d);
			end
			// shift-register-empty has no meaning in master mode
			chk("master end", (cfg & 8'h70) | 8'h04, d & 8'hFD);
			chk("sck idle", {7'h00, cfg[4]}, {7'h00, sck_out});
			rd(`SCS_ADDR_DATA, d);
			chk("master rx", v, d);
			// four-wire master drives its select from control bit 2
			wr(`SCS_ADDR_CONTROL, 8'h09);
			chk("select drive", 8'h02, {6'h00, ss_oe, ss_out});
			wr(`SCS_ADDR_CONTROL, 8'h00);
		end
	endtask
	initial begin
		err_count = 0;
		checks_done = 0;
		arst_n = 1'b0;
		ce = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		repeat (2) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_reset_access;
		t_pin;
		t_slave;
		t_master(8'h50, 8'h96);
		t_master(8'h60, 8'h5A);
		end_sim;
	end
endmodule // tb
